//--- design/gcp_consts.svh
// register offsets, field positions, reset values and codes of the pin control block
`ifndef GCP_CONSTS_SVH
`define GCP_CONSTS_SVH

`define GCP_NPINS        5
`define GCP_ADR_W        8

`define GCP_OFS_DIR      8'h00
`define GCP_OFS_DOUT     8'h04
`define GCP_OFS_PULL_EN  8'h08
`define GCP_OFS_PULL_UP  8'h0c
`define GCP_OFS_COEX     8'h10
`define GCP_OFS_PIN_IN   8'h14

`define GCP_RST_DIR      5'h00
`define GCP_RST_DOUT     5'h00
`define GCP_RST_PULL_EN  5'h00
`define GCP_RST_PULL_UP  5'h00
`define GCP_RST_MODE     2'h0
`define GCP_RST_WAKE_EN  1'h0

`define GCP_MODE_LSB     0
`define GCP_WAKE_EN_BIT  4
`define GCP_STAT_LSB     8

`define GCP_MODE_OFF     2'h0
`define GCP_MODE_2W      2'h1
`define GCP_MODE_3W      2'h2
`define GCP_MODE_4W      2'h3

`endif

//--- design/gcp_pkg.sv
// types of the pin control and coexistence block
`include "gcp_consts.svh"
`default_nettype none
package gcp_pkg;
	typedef struct packed {
		logic [`GCP_NPINS-1:0] dir;
		logic [`GCP_NPINS-1:0] dout;
		logic [`GCP_NPINS-1:0] pull_en;
		logic [`GCP_NPINS-1:0] pull_up;
		logic [1:0]            mode;
		logic                  wake_en;
		logic [`GCP_NPINS-1:0] sync1;
		logic [`GCP_NPINS-1:0] sync2;
		logic [`GCP_NPINS-1:0] pad_out;
		logic [`GCP_NPINS-1:0] pad_oe;
		logic                  serial_rx;
		logic                  frame_sync;
		logic                  peer_rx;
		logic                  peer_tx;
		logic                  ack;
		logic [31:0]           rdata;
	} gcp_state_t;
endpackage : gcp_pkg
`default_nettype wire

//--- design/gcp_pin_ctrl.sv
// general-purpose pins with coexistence pin sharing and a wishbone register port
`include "gcp_consts.svh"
`default_nettype none

module gcp_pin_ctrl (
	input  wire logic                  clk_i,            // 10 MHz clock
	input  wire logic                  rst_i,            // synchronous reset, active high
	input  wire logic                  ce_i,             // clock enable, freezes state when low
	input  wire logic                  cyc_i,            // wishbone cycle
	input  wire logic                  stb_i,            // wishbone strobe
	input  wire logic                  we_i,             // wishbone write enable
	input  wire logic [`GCP_ADR_W-1:0] adr_i,            // wishbone byte address
	input  wire logic [3:0]            sel_i,            // wishbone byte selects
	input  wire logic [31:0]           dat_i,            // wishbone write data
	output logic                       ack_o,            // wishbone acknowledge
	output logic [31:0]                dat_o,            // wishbone read data
	input  wire logic                  host_wake_i,      // host wake level from core
	input  wire logic                  coex_serial_tx_i, // serial coexistence data from core
	input  wire logic                  coex_prio_i,      // priority level from core
	output logic                       coex_serial_rx_o, // serial coexistence data from peer
	output logic                       frame_sync_o,     // peer frame sync
	output logic                       peer_rx_active_o, // peer receiving
	output logic                       peer_tx_active_o, // peer transmitting
	input  wire logic [`GCP_NPINS-1:0] pad_i,            // pad input levels
	output logic [`GCP_NPINS-1:0]      pad_o,            // pad output levels
	output logic [`GCP_NPINS-1:0]      pad_oe_o,         // pad output enables, high drives
	output logic [`GCP_NPINS-1:0]      pull_en_o,        // pad pull resistor enables
	output logic [`GCP_NPINS-1:0]      pull_up_o         // pad pull select, high pulls up
);

	gcp_pkg::gcp_state_t st_r;
	gcp_pkg::gcp_state_t st_nxt;

	logic                  acc;
	logic                  wr;
	logic [`GCP_NPINS-1:0] drv_oe;
	logic [`GCP_NPINS-1:0] drv_out;

	// byte-lane merge of a narrow register
	function automatic logic [`GCP_NPINS-1:0] lane_merge(
		input logic [`GCP_NPINS-1:0] old_v,
		input logic [31:0]           wdat,
		input logic [3:0]            sel
	);
		logic [`GCP_NPINS-1:0] res;
		res = old_v;
		if (sel[0]) begin
			res = wdat[`GCP_NPINS-1:0];
		end
		return res;
	endfunction : lane_merge

	// peer input valid only in the listed modes
	function automatic logic mode_in(
		input logic [1:0] mode,
		input logic       in2w,
		input logic       in3w,
		input logic       in4w
	);
		logic res;
		res = 1'b0;
		case (mode)
			`GCP_MODE_2W: res = in2w;
			`GCP_MODE_3W: res = in3w;
			`GCP_MODE_4W: res = in4w;
			default:      res = 1'b0;
		endcase
		return res;
	endfunction : mode_in

	assign acc = cyc_i & stb_i & ~st_r.ack;
	assign wr  = acc & we_i;

	// pin drive: general setting, then host wake, then coexistence overrides
	always_comb begin
		drv_oe  = st_r.dir;
		drv_out = st_r.dout;
		if (st_r.wake_en) begin
			drv_oe[0]  = 1'b1;
			drv_out[0] = host_wake_i;
		end
		case (st_r.mode)
			`GCP_MODE_2W: begin
				drv_oe[1]  = 1'b1;
				drv_out[1] = coex_serial_tx_i;
				drv_oe[2]  = 1'b0;
			end
			`GCP_MODE_3W: begin
				drv_oe[2]  = 1'b1;
				drv_out[2] = coex_prio_i;
				drv_oe[3]  = 1'b0;
				drv_oe[4]  = 1'b0;
			end
			`GCP_MODE_4W: begin
				drv_oe[1]  = 1'b1;
				drv_out[1] = coex_prio_i;
				drv_oe[2]  = 1'b0;
				drv_oe[3]  = 1'b0;
				drv_oe[4]  = 1'b0;
			end
			default: begin
				drv_oe[4:1]  = st_r.dir[4:1];
				drv_out[4:1] = st_r.dout[4:1];
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		// pad inputs cross into the clock domain
		st_nxt.sync1 = pad_i;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.pad_oe  = drv_oe;
		st_nxt.pad_out = drv_out;
		st_nxt.serial_rx  = mode_in(st_r.mode, st_r.sync2[2], 1'b0, 1'b0);
		st_nxt.frame_sync = mode_in(st_r.mode, 1'b0, 1'b0, st_r.sync2[2]);
		st_nxt.peer_rx    = mode_in(st_r.mode, 1'b0, st_r.sync2[3], st_r.sync2[3]);
		st_nxt.peer_tx    = mode_in(st_r.mode, 1'b0, st_r.sync2[4], st_r.sync2[4]);
		st_nxt.ack   = acc;
		st_nxt.rdata = 32'h0000_0000;
		if (wr) begin
			case (adr_i)
				`GCP_OFS_DIR:     st_nxt.dir     = lane_merge(st_r.dir, dat_i, sel_i);
				`GCP_OFS_DOUT:    st_nxt.dout    = lane_merge(st_r.dout, dat_i, sel_i);
				`GCP_OFS_PULL_EN: st_nxt.pull_en = lane_merge(st_r.pull_en, dat_i, sel_i);
				`GCP_OFS_PULL_UP: st_nxt.pull_up = lane_merge(st_r.pull_up, dat_i, sel_i);
				`GCP_OFS_COEX: begin
					if (sel_i[0]) begin
						st_nxt.mode    = dat_i[`GCP_MODE_LSB+:2];
						st_nxt.wake_en = dat_i[`GCP_WAKE_EN_BIT];
					end
				end
				default: st_nxt.dir = st_r.dir;
			endcase
		end else if (acc) begin
			case (adr_i)
				`GCP_OFS_DIR:     st_nxt.rdata[`GCP_NPINS-1:0] = st_r.dir;
				`GCP_OFS_DOUT:    st_nxt.rdata[`GCP_NPINS-1:0] = st_r.dout;
				`GCP_OFS_PULL_EN: st_nxt.rdata[`GCP_NPINS-1:0] = st_r.pull_en;
				`GCP_OFS_PULL_UP: st_nxt.rdata[`GCP_NPINS-1:0] = st_r.pull_up;
				`GCP_OFS_COEX: begin
					st_nxt.rdata[`GCP_MODE_LSB+:2]   = st_r.mode;
					st_nxt.rdata[`GCP_WAKE_EN_BIT]   = st_r.wake_en;
				end
				`GCP_OFS_PIN_IN: begin
					st_nxt.rdata[`GCP_NPINS-1:0]     = st_r.sync2;
					st_nxt.rdata[`GCP_STAT_LSB+:4]   = {st_r.peer_tx, st_r.peer_rx,
						st_r.frame_sync, st_r.serial_rx};
				end
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r         <= '0;
			st_r.dir     <= `GCP_RST_DIR;
			st_r.dout    <= `GCP_RST_DOUT;
			st_r.pull_en <= `GCP_RST_PULL_EN;
			st_r.pull_up <= `GCP_RST_PULL_UP;
			st_r.mode    <= `GCP_RST_MODE;
			st_r.wake_en <= `GCP_RST_WAKE_EN;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign ack_o            = st_r.ack;
	assign dat_o            = st_r.rdata;
	assign coex_serial_rx_o = st_r.serial_rx;
	assign frame_sync_o     = st_r.frame_sync;
	assign peer_rx_active_o = st_r.peer_rx;
	assign peer_tx_active_o = st_r.peer_tx;
	assign pad_o            = st_r.pad_out;
	assign pad_oe_o         = st_r.pad_oe;
	assign pull_en_o        = st_r.pull_en;
	assign pull_up_o        = st_r.pull_up;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_RST_TRISTATE: assert property (
		$fell(rst_i) |-> (pad_oe_o == 5'h00) && (st_r.mode == `GCP_MODE_OFF) && !st_r.wake_en
	) else $error("pins not tristated after reset");

	AST_DIR_WRITE: assert property (
		(ce_i && cyc_i && stb_i && we_i && !ack_o && adr_i == `GCP_OFS_DIR && sel_i[0])
		|=> (st_r.dir == $past(dat_i[`GCP_NPINS-1:0])) && ack_o
	) else $error("direction write lost");

	AST_GENERAL_PASS: assert property (
		(ce_i && st_r.mode == `GCP_MODE_OFF && !st_r.wake_en)
		|=> (pad_oe_o == $past(st_r.dir)) && (pad_o == $past(st_r.dout))
	) else $error("general pin setting not applied");

	AST_PULL_WRITE: assert property (
		(ce_i && cyc_i && stb_i && we_i && !ack_o && adr_i == `GCP_OFS_PULL_UP && sel_i[0])
		|=> pull_up_o == $past(dat_i[`GCP_NPINS-1:0])
	) else $error("pull select write lost");

	AST_HOST_WAKE: assert property (
		(ce_i && st_r.wake_en) |=> pad_oe_o[0] && (pad_o[0] == $past(host_wake_i))
	) else $error("host wake not driven on pin 0");

	AST_TWO_WIRE: assert property (
		(ce_i && st_r.mode == `GCP_MODE_2W)
		|=> (pad_oe_o[2:1] == 2'b01) && (pad_o[1] == $past(coex_serial_tx_i))
	) else $error("two-wire pin roles wrong");

	AST_THREE_WIRE: assert property (
		(ce_i && st_r.mode == `GCP_MODE_3W)
		|=> (pad_oe_o[4:2] == 3'b001) && (pad_o[2] == $past(coex_prio_i))
	) else $error("three-wire pin roles wrong");

	AST_FOUR_WIRE: assert property (
		(ce_i && st_r.mode == `GCP_MODE_4W)
		|=> (pad_oe_o[4:1] == 4'b0001) && (pad_o[1] == $past(coex_prio_i))
	) else $error("four-wire pin roles wrong");

	AST_PEER_PATH: assert property (
		(ce_i && st_r.mode == `GCP_MODE_4W) [*3]
		|=> (peer_tx_active_o == $past(pad_i[4], 3)) && (frame_sync_o == $past(pad_i[2], 3))
	) else $error("peer input path delay wrong");

	AST_NO_SYNC_OUT: assert property (
		(ce_i && st_r.mode != `GCP_MODE_4W) |=> !frame_sync_o
	) else $error("frame sync outside four-wire mode");

	AST_PIN0_GENERAL: assert property (
		(ce_i && !st_r.wake_en)
		|=> (pad_oe_o[0] == $past(st_r.dir[0])) && (pad_o[0] == $past(st_r.dout[0]))
	) else $error("pin 0 general setting not applied");

	AST_THREE_WIRE_PIN1: assert property (
		(ce_i && st_r.mode == `GCP_MODE_3W)
		|=> (pad_oe_o[1] == $past(st_r.dir[1])) && (pad_o[1] == $past(st_r.dout[1]))
	) else $error("pin 1 not general in three-wire mode");

	AST_TWO_WIRE_GENERAL: assert property (
		(ce_i && st_r.mode == `GCP_MODE_2W)
		|=> (pad_oe_o[4:3] == $past(st_r.dir[4:3])) && (pad_o[4:3] == $past(st_r.dout[4:3]))
	) else $error("pins 3 and 4 not general in two-wire mode");

	AST_SERIAL_PATH: assert property (
		(ce_i && st_r.mode == `GCP_MODE_2W) [*3]
		|=> coex_serial_rx_o == $past(pad_i[2], 3)
	) else $error("serial input path delay wrong");

	AST_PEER_RX_PATH: assert property (
		(ce_i && st_r.mode == `GCP_MODE_3W) [*3]
		|=> peer_rx_active_o == $past(pad_i[3], 3)
	) else $error("three-wire receive activity path wrong");

	AST_PEER_TX3_PATH: assert property (
		(ce_i && st_r.mode == `GCP_MODE_3W) [*3]
		|=> peer_tx_active_o == $past(pad_i[4], 3)
	) else $error("three-wire transmit activity path wrong");

	AST_RX4_PATH: assert property (
		(ce_i && st_r.mode == `GCP_MODE_4W) [*3]
		|=> peer_rx_active_o == $past(pad_i[3], 3)
	) else $error("four-wire receive activity path wrong");

	AST_RX_SERIAL: assert property (
		(ce_i && st_r.mode != `GCP_MODE_2W)
		|=> !coex_serial_rx_o
	) else $error("serial input outside two-wire mode");

	AST_PEER_OFF: assert property (
		(ce_i && !st_r.mode[1])
		|=> !peer_rx_active_o && !peer_tx_active_o
	) else $error("peer activity outside three or four-wire mode");

	AST_DOUT_WRITE: assert property (
		(ce_i && cyc_i && stb_i && we_i && !ack_o && adr_i == `GCP_OFS_DOUT && sel_i[0])
		|=> st_r.dout == $past(dat_i[`GCP_NPINS-1:0])
	) else $error("output value write lost");

	AST_PULL_EN_WRITE: assert property (
		(ce_i && cyc_i && stb_i && we_i && !ack_o && adr_i == `GCP_OFS_PULL_EN && sel_i[0])
		|=> pull_en_o == $past(dat_i[`GCP_NPINS-1:0])
	) else $error("pull enable write lost");

	AST_COEX_WRITE: assert property (
		(ce_i && cyc_i && stb_i && we_i && !ack_o && adr_i == `GCP_OFS_COEX && sel_i[0])
		|=> (st_r.mode == $past(dat_i[1:0])) && (st_r.wake_en == $past(dat_i[4]))
	) else $error("mode write lost");

	AST_SEL_IGNORED: assert property (
		(ce_i && cyc_i && stb_i && we_i && !ack_o && adr_i == `GCP_OFS_DIR && !sel_i[0])
		|=> $stable(st_r.dir)
	) else $error("write without low lane changed direction");

	AST_UNMAPPED_WRITE: assert property (
		(ce_i && cyc_i && stb_i && we_i && !ack_o && adr_i[7:4] != 4'h0 && adr_i != `GCP_OFS_COEX)
		|=> $stable(st_r.dir) && $stable(st_r.mode) && $stable(st_r.dout)
	) else $error("unmapped write changed a register");

	AST_READ_DIR: assert property (
		(ce_i && cyc_i && stb_i && !we_i && !ack_o && adr_i == `GCP_OFS_DIR)
		|=> dat_o == {27'h0000000, $past(st_r.dir)}
	) else $error("direction read wrong");

	AST_READ_COEX: assert property (
		(ce_i && cyc_i && stb_i && !we_i && !ack_o && adr_i == `GCP_OFS_COEX)
		|=> dat_o == {27'h0000000, $past(st_r.wake_en), 2'h0, $past(st_r.mode)}
	) else $error("mode read wrong");

	AST_FREEZE: assert property (
		!ce_i
		|=> $stable(st_r)
	) else $error("state changed while clock enable low");

	AST_ACK_PULSE: assert property (
		(ce_i && ack_o)
		|=> !ack_o
	) else $error("acknowledge longer than one cycle");

	AST_ACK_REQ: assert property (
		(ce_i && cyc_i && stb_i && !ack_o)
		|=> ack_o
	) else $error("request not acknowledged");

	AST_NO_SPURIOUS_ACK: assert property (
		(ce_i && !(cyc_i && stb_i))
		|=> !ack_o
	) else $error("acknowledge without request");

	AST_RDATA_IDLE: assert property (
		!ack_o
		|-> dat_o == 32'h00000000
	) else $error("read data not zero outside acknowledge");

endmodule : gcp_pin_ctrl
`default_nettype wire

//--- dv/gcp_peer_model.sv
// colocated radio model with pad wire resolution
`default_nettype none
module gcp_peer_model (
	input  wire logic       clk_i,     // system clock
	input  wire logic       rst_i,     // synchronous reset
	input  wire logic [1:0] mode_i,    // link mode in use
	input  wire logic [4:0] val_i,     // levels the radio sends
	input  wire logic [4:0] pad_o_i,   // device drive values
	input  wire logic [4:0] pad_oe_i,  // device drive enables
	input  wire logic [4:0] pull_en_i, // pull enables
	input  wire logic [4:0] pull_up_i, // pull select
	output logic      [4:0] wire_o     // resolved pad levels
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] drv;
	logic [4:0] tgl_r;
	// undriven unpulled pins wander
	always_ff @(posedge clk_i) begin
		tgl_r <= rst_i ? 5'h15 : ~tgl_r;
	end
	always_comb begin
		case (mode_i)
			2'h1: drv = 5'h04;
			2'h2: drv = 5'h18;
			2'h3: drv = 5'h1c;
			default: drv = 5'h00;
		endcase
	end
	always_comb begin
		for (int k = 0; k < 5; k++) begin
			wire_o[k] = pad_oe_i[k] ? pad_o_i[k] : drv[k] ? val_i[k] : pull_en_i[k] ? pull_up_i[k] : tgl_r[k];
		end
	end
endmodule : gcp_peer_model
`default_nettype wire

//--- dv/tb.sv
// self-checking bench of the pin control block
`include "gcp_consts.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, hw = 0, stx = 0, pr = 0;
	logic srx, fs, prx, ptx;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0, dout_w, q, seed = 32'h338c2937;
	logic [4:0]  pad_w, po, poe, pen, pup, dir, dv, pe, pu, pv = 5'h00, m;
	logic [1:0]  pm = 2'h0;
	logic        ce = 1'b1;
	logic [3:0]  sel = 4'hf;
	int err_total = 0, checks_done = 0;
	always #50 clk_i = ~clk_i;
	gcp_pin_ctrl gcp_pin_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .ack_o(ack), .dat_o(dout_w), .host_wake_i(hw),
		.coex_serial_tx_i(stx), .coex_prio_i(pr), .coex_serial_rx_o(srx), .frame_sync_o(fs),
		.peer_rx_active_o(prx), .peer_tx_active_o(ptx), .pad_i(pad_w), .pad_o(po), .pad_oe_o(poe),
		.pull_en_o(pen), .pull_up_o(pup));
	gcp_peer_model gcp_peer_model_i (.clk_i(clk_i), .rst_i(rst_i), .mode_i(pm), .val_i(pv), .pad_o_i(po),
		.pad_oe_i(poe), .pull_en_i(pen), .pull_up_i(pup), .wire_o(pad_w));
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [4:0] exp_oe(logic [1:0] md, logic w, logic [4:0] d);
		logic [4:0] e;
		e = d;
		if (w) e[0] = 1'b1;
		case (md)
			2'h1: e[2:1] = 2'h1;
			2'h2: e[4:2] = 3'h1;
			2'h3: e[4:1] = 4'h1;
			default: ;
		endcase
		return e;
	endfunction : exp_oe
	function automatic logic [4:0] exp_out(logic [1:0] md, logic w, logic [4:0] d);
		logic [4:0] e;
		e = d;
		if (w) e[0] = hw;
		if (md == 2'h1) e[1] = stx;
		if (md == 2'h2) e[2] = pr;
		if (md == 2'h3) e[1] = pr;
		return e;
	endfunction : exp_out
	task complete_run;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
			err_total++;
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(0, 1, "bus timeout");
			complete_run();
		end
		q = dout_w;
		{cyc, stb, we} <= 3'h0;
	endtask : wb
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk(poe, 0, "tristate after reset");
		chk({srx, fs, prx, ptx}, 0, "status after reset");
		wb(0, `GCP_OFS_COEX, 0); chk(q, 0, "mode after reset");
		for (int i = 0; i < 4; i++) begin
			q = xs();
			{dir, dv, pe, pu} = q[19:0];
			wb(1, `GCP_OFS_DIR, dir); wb(1, `GCP_OFS_DOUT, dv);
			wb(1, `GCP_OFS_PULL_EN, pe); wb(1, `GCP_OFS_PULL_UP, pu);
			wb(0, `GCP_OFS_DIR, 0); chk(q, {27'h0, dir}, "dir readback");
			repeat (4) @(negedge clk_i);
			chk(poe, dir, "pad enables");
			chk(po & dir, dv & dir, "pad values");
			chk({pen, pup}, {pe, pu}, "pulls");
			m = dir | pe;
			wb(0, `GCP_OFS_PIN_IN, 0);
			chk(q[4:0] & m, ((dv & dir) | (pu & ~dir)) & m, "pin levels");
		end
		for (int i = 0; i < 8; i++) begin
			wb(1, `GCP_OFS_COEX, {i[2], 2'h0, i[1:0]});
			@(posedge clk_i);
			q = xs();
			{hw, stx, pr, pv} <= q[7:0];
			pm <= i[1:0];
			repeat (4) @(negedge clk_i);
			m = exp_oe(i[1:0], i[2], dir);
			chk(poe, m, "coex enables");
			chk(po & m, exp_out(i[1:0], i[2], dv) & m, "coex drive");
			chk({srx, fs, prx, ptx}, {i[1:0] == 2'h1 && pv[2], i[1:0] == 2'h3 && pv[2],
				i[1] && pv[3], i[1] && pv[4]}, "peer status");
			wb(0, `GCP_OFS_PIN_IN, 0);
			chk(q[11:8], {i[1] && pv[4], i[1] && pv[3], i[1:0] == 2'h3 && pv[2],
				i[1:0] == 2'h1 && pv[2]}, "status readback");
		end
		wb(1, 8'h20, 32'hffffffff); wb(0, 8'h20, 0); chk(q, 0, "unmapped read");
		@(posedge clk_i);
		sel <= 4'he;
		wb(1, `GCP_OFS_DIR, {27'h0, ~dir});
		@(posedge clk_i);
		sel <= 4'hf;
		wb(0, `GCP_OFS_DIR, 0); chk(q, {27'h0, dir}, "dir kept");
		m = po;
		@(posedge clk_i);
		ce <= 1'b0;
		hw <= ~hw;
		pr <= ~pr;
		repeat (4) @(negedge clk_i);
		chk(po, m, "frozen while disabled");
		@(posedge clk_i);
		ce <= 1'b1;
		repeat (4) @(negedge clk_i);
		chk(po[1:0], {pr, hw}, "running after enable");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({poe, srx, fs, prx, ptx}, 0, "tristate after second reset");
		wb(0, `GCP_OFS_DIR, 0); chk(q, 0, "dir cleared by reset");
		complete_run();
	end
endmodule : tb
`default_nettype wire
